/* File: intc_pkg.sv */
// shared offsets, field positions, masks and reset values of the interrupt control block
`default_nettype none
package intc_pkg;

  // register byte offsets on the wishbone bus, one 32-bit word each
  localparam logic [7:0]  CTL1_OFS       = 8'h00;
  localparam logic [7:0]  CTL2_OFS       = 8'h04;
  localparam logic [7:0]  FLAGS0_OFS     = 8'h08;
  localparam logic [7:0]  FLAGS1_OFS     = 8'h0C;

  // control register one fields
  localparam int          NEST_BIT       = 15;
  localparam int          ARITH_BIT      = 4;
  localparam int          ADDR_BIT       = 3;
  localparam int          STACK_BIT      = 2;
  localparam int          OSC_BIT        = 1;
  localparam int          TRAP_LSB       = 1;
  localparam int          TRAP_W         = 4;

  // control register two fields
  localparam int          ALT_BIT        = 15;
  localparam int          TDIS_BIT       = 14;
  localparam int          EXT_COUNT      = 5;

  // implemented bits of each register
  localparam logic [15:0] CTL1_MASK      = 16'h801E;
  localparam logic [15:0] CTL2_MASK      = 16'hC01F;
  localparam logic [15:0] FLAGS0_MASK    = 16'h7FFF;
  localparam logic [15:0] FLAGS1_MASK    = 16'hFF5F;
  localparam logic [TRAP_W-1:0] TRAP_MASK = 4'hF;

  // where the external edge detectors land in the flag registers
  localparam int          EXT0_FLAG_BIT  = 0;
  localparam int          EXT1_FLAG_BIT  = 4;
  localparam int          EXT2_FLAG_BIT  = 13;

  // values after power-on reset
  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [4:0]  POL_RESET      = 5'h00;
  localparam logic        BIT_RESET      = 1'b0;

endpackage
`default_nettype wire

/* File: ext_edge_detect.sv */
// two-flop synchroniser and selectable-polarity edge detector for one external pin
`timescale 1ns/100ps
`default_nettype none
module ext_edge_detect
  import intc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic pin,
  input  wire logic fallingEdge,
  output logic      edgePulse
);

  typedef struct packed {
    logic meta;
    logic sync;
    logic prev;
    logic pulse;
  } edge_state_t;

  edge_state_t state_q;
  edge_state_t state_d;

  // meta feeds only sync; the edge logic looks at sync and prev
  always_comb
  begin
    state_d       = state_q;
    state_d.meta  = pin;
    state_d.sync  = state_q.meta;
    state_d.prev  = state_q.sync;
    state_d.pulse = fallingEdge ? (state_q.prev & ~state_q.sync)
                                : (~state_q.prev & state_q.sync);
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign edgePulse = state_q.pulse;

endmodule
`default_nettype wire

/* File: sticky_flags.sv */
// bank of sticky request flags: hardware sets, software writes, set beats clear
`timescale 1ns/100ps
`default_nettype none
module sticky_flags
  import intc_pkg::*;
#(
  parameter int               WIDTH = 16,
  parameter logic [WIDTH-1:0] IMPL  = '1
)
(
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrMask,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [WIDTH-1:0] set,
  output logic      [WIDTH-1:0] flags
);

  typedef struct packed {
    logic [WIDTH-1:0] bits;
  } flag_state_t;

  flag_state_t state_q;
  flag_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (wrEn)
      state_d.bits = (state_q.bits & ~wrMask) | (wrData & wrMask);
    // a request in the clearing cycle is kept, never lost
    state_d.bits = (state_d.bits | set) & IMPL;
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
      state_q <= '0;
    else
      state_q <= state_d;
  end

  assign flags = state_q.bits;

endmodule
`default_nettype wire

/* File: interrupt_control_flags.sv */
// interrupt controller global control, trap status and request flag registers
`timescale 1ns/100ps
`default_nettype none
module interrupt_control_flags
  import intc_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        arithTrap,
  input  wire logic        addressTrap,
  input  wire logic        stackTrap,
  input  wire logic        oscFailTrap,
  input  wire logic        timedDisableActive,
  input  wire logic [4:0]  extPin,
  input  wire logic [15:0] periphReq0,
  input  wire logic [15:0] periphReq1,
  input  wire logic        iplWriteReq,
  output logic             iplWriteAllow,
  output logic             nestDisable,
  output logic             altVectorSelect,
  output logic      [4:0]  extEdge,
  output logic      [15:0] requestFlags0,
  output logic      [15:0] requestFlags1
);

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
    logic        nest;
    logic        altVec;
    logic [4:0]  polarity;
  } ctl_state_t;

  ctl_state_t state_q;
  ctl_state_t state_d;

  logic              wbReq;
  logic              wrStrobe;
  logic [15:0]       laneMask;
  logic              wrCtl1;
  logic              wrCtl2;
  logic              wrFlags0;
  logic              wrFlags1;
  logic [TRAP_W-1:0] trapSet;
  logic [TRAP_W-1:0] trapFlags;
  logic [15:0]       ctl1View;
  logic [15:0]       ctl2View;
  logic [15:0]       set0;
  logic [15:0]       set1;
  logic [15:0]       readMux;

  // ---------------------------------------------------------------
  // wishbone slave: ack one cycle after the request, held one cycle;
  // writes land on the ack edge so the master sees them committed
  // ---------------------------------------------------------------
  assign wbReq    = wb_cyc_i & wb_stb_i;
  assign wrStrobe = wbReq & state_q.ack & wb_we_i;
  assign laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wrCtl1   = wrStrobe && (wb_adr_i == CTL1_OFS);
  assign wrCtl2   = wrStrobe && (wb_adr_i == CTL2_OFS);
  assign wrFlags0 = wrStrobe && (wb_adr_i == FLAGS0_OFS);
  assign wrFlags1 = wrStrobe && (wb_adr_i == FLAGS1_OFS);

  // ---------------------------------------------------------------
  // external pins: synchronised, then edge chosen by polarity
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < EXT_COUNT; gi++)
    begin : g_ext
      ext_edge_detect u_edge (
        .core_clk    (core_clk),
        .reset_n     (reset_n),
        .pin         (extPin[gi]),
        .fallingEdge (state_q.polarity[gi]),
        .edgePulse   (extEdge[gi])
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // trap status flags, ordered arith/address/stack/osc on bits 4..1
  // ---------------------------------------------------------------
  always_comb
  begin
    trapSet = {arithTrap, addressTrap, stackTrap, oscFailTrap};
  end

  sticky_flags #(
    .WIDTH (TRAP_W),
    .IMPL  (TRAP_MASK)
  ) u_traps (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wrEn     (wrCtl1),
    .wrMask   (laneMask[TRAP_LSB +: TRAP_W]),
    .wrData   (wb_dat_i[TRAP_LSB +: TRAP_W]),
    .set      (trapSet),
    .flags    (trapFlags)
  );

  // ---------------------------------------------------------------
  // request flags: peripheral requests plus pin edges
  // ext3 and ext4 flag elsewhere; their edges are only passed out
  // ---------------------------------------------------------------
  always_comb
  begin
    set0                = periphReq0;
    set1                = periphReq1;
    set0[EXT0_FLAG_BIT] = periphReq0[EXT0_FLAG_BIT] | extEdge[0];
    set1[EXT1_FLAG_BIT] = periphReq1[EXT1_FLAG_BIT] | extEdge[1];
    set1[EXT2_FLAG_BIT] = periphReq1[EXT2_FLAG_BIT] | extEdge[2];
  end

  sticky_flags #(
    .WIDTH (16),
    .IMPL  (FLAGS0_MASK)
  ) u_flags0 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wrEn     (wrFlags0),
    .wrMask   (laneMask),
    .wrData   (wb_dat_i[15:0]),
    .set      (set0),
    .flags    (requestFlags0)
  );

  sticky_flags #(
    .WIDTH (16),
    .IMPL  (FLAGS1_MASK)
  ) u_flags1 (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .wrEn     (wrFlags1),
    .wrMask   (laneMask),
    .wrData   (wb_dat_i[15:0]),
    .set      (set1),
    .flags    (requestFlags1)
  );

  // ---------------------------------------------------------------
  // read views of the two control registers
  // ---------------------------------------------------------------
  always_comb
  begin
    ctl1View                         = REG_RESET;
    ctl1View[NEST_BIT]               = state_q.nest;
    ctl1View[TRAP_LSB +: TRAP_W]     = trapFlags;
    ctl2View                         = REG_RESET;
    ctl2View[ALT_BIT]                = state_q.altVec;
    ctl2View[TDIS_BIT]               = timedDisableActive;
    ctl2View[EXT_COUNT-1:0]          = state_q.polarity;
  end

  always_comb
  begin
    case (wb_adr_i)
      CTL1_OFS:   readMux = ctl1View & CTL1_MASK;
      CTL2_OFS:   readMux = ctl2View & CTL2_MASK;
      FLAGS0_OFS: readMux = requestFlags0;
      FLAGS1_OFS: readMux = requestFlags1;
      default:    readMux = REG_RESET;
    endcase
  end

  // ---------------------------------------------------------------
  // control state
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d     = state_q;
    state_d.ack = wbReq & ~state_q.ack;
    if (wbReq && !state_q.ack)
      state_d.rdata = readMux;
    if (wrCtl1 && wb_sel_i[1])
      state_d.nest = wb_dat_i[NEST_BIT];
    if (wrCtl2 && wb_sel_i[1])
      state_d.altVec = wb_dat_i[ALT_BIT];
    if (wrCtl2 && wb_sel_i[0])
      state_d.polarity = wb_dat_i[EXT_COUNT-1:0];
  end

  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_q          <= '0;
      state_q.rdata    <= REG_RESET;
      state_q.polarity <= POL_RESET;
      state_q.nest     <= BIT_RESET;
      state_q.altVec   <= BIT_RESET;
    end
    else
      state_q <= state_d;
  end

  assign wb_ack_o        = state_q.ack;
  assign wb_dat_o        = {16'h0000, state_q.rdata};
  assign nestDisable     = state_q.nest;
  assign altVectorSelect = state_q.altVec;
  // priority level writes are refused whole while nesting is off
  assign iplWriteAllow   = iplWriteReq & ~state_q.nest;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_newReq;
    wbReq && !state_q.ack;
  endsequence

  sequence s_ackPulse;
    state_q.ack ##1 !state_q.ack;
  endsequence

  sequence s_fall0;
    $fell(extPin[0]) ##0 state_q.polarity[0] [*4];
  endsequence

  sequence s_rise1;
    $rose(extPin[1]) ##0 !state_q.polarity[1] [*4];
  endsequence

  a_ack_timing: assert property (s_newReq |=> s_ackPulse)
    else $error("ack not given for exactly one cycle after request");

  a_nest_write: assert property (
    (wrCtl1 && wb_sel_i[1]) |=> (nestDisable == $past(wb_dat_i[NEST_BIT])))
    else $error("nest disable did not follow write");

  a_arith_trap: assert property (
    (arithTrap && !wrCtl1) ##1 !wrCtl1 |-> trapFlags[ARITH_BIT-TRAP_LSB] [*2])
    else $error("arithmetic trap flag not set and held");

  a_addr_trap: assert property (
    addressTrap |=> trapFlags[ADDR_BIT-TRAP_LSB])
    else $error("address trap flag not set");

  a_stack_trap: assert property (
    stackTrap |=> trapFlags[STACK_BIT-TRAP_LSB])
    else $error("stack trap flag not set");

  a_osc_trap: assert property (
    oscFailTrap |=> trapFlags[OSC_BIT-TRAP_LSB])
    else $error("oscillator trap flag not set");

  a_ctl1_unused: assert property (
    (s_newReq ##0 (wb_adr_i == CTL1_OFS)) |=>
      (wb_dat_o[14:5] == 10'h000) && !wb_dat_o[0] && wb_ack_o)
    else $error("unused control-one bits read nonzero");

  a_alt_vector: assert property (
    (wrCtl2 && wb_sel_i[1]) |=> (altVectorSelect == $past(wb_dat_i[ALT_BIT])))
    else $error("alternate vector select did not follow write");

  a_tdis_read: assert property (
    (s_newReq ##0 (wb_adr_i == CTL2_OFS)) |=>
      (wb_dat_o[TDIS_BIT] == $past(timedDisableActive)))
    else $error("timed disable status read wrong");

  a_tdis_nowrite: assert property (
    (wrCtl2 && !timedDisableActive) ##1 !timedDisableActive |-> !ctl2View[TDIS_BIT])
    else $error("timed disable bit took a software write");

  a_fall_edge: assert property (s_fall0 |-> extEdge[0])
    else $error("falling edge on ext0 not detected");

  a_rise_edge: assert property (s_rise1 |-> extEdge[1])
    else $error("rising edge on ext1 not detected");

  a_flag_write: assert property (
    (wrFlags0 && (wb_sel_i[1:0] == 2'b11) && (periphReq0 == 16'h0000) && !extEdge[0])
      |=> (requestFlags0 == ($past(wb_dat_i[15:0]) & FLAGS0_MASK)))
    else $error("flag register zero write not stored");

  a_flags0_map: assert property (
    (periphReq0 != 16'h0000) |=>
      ((requestFlags0 & $past(periphReq0) & FLAGS0_MASK)
        == ($past(periphReq0) & FLAGS0_MASK)))
    else $error("flag register zero missed a request");

  a_flags1_map: assert property (
    (periphReq1 != 16'h0000) |=>
      ((requestFlags1 & $past(periphReq1) & FLAGS1_MASK)
        == ($past(periphReq1) & FLAGS1_MASK)))
    else $error("flag register one missed a request");

  a_reserved_zero: assert property (
    !requestFlags0[15] && !requestFlags1[7] && !requestFlags1[5])
    else $error("unimplemented flag bit set");

  a_ext_to_flag: assert property (
    extEdge[0] || extEdge[1] || extEdge[2] |=>
      (!$past(extEdge[0]) || requestFlags0[EXT0_FLAG_BIT]) &&
      (!$past(extEdge[1]) || requestFlags1[EXT1_FLAG_BIT]) &&
      (!$past(extEdge[2]) || requestFlags1[EXT2_FLAG_BIT]))
    else $error("external edge did not set its flag");

  a_set_beats_clr: assert property (
    (wrFlags1 && wb_sel_i[0] && !wb_dat_i[0] && periphReq1[0]) |=> requestFlags1[0])
    else $error("request lost against software clear");

  a_no_self_clear: assert property (
    (requestFlags0[3] && !wrFlags0) |=> requestFlags0[3])
    else $error("flag cleared without software write");

  a_ipl_locked: assert property (
    nestDisable |-> !iplWriteAllow)
    else $error("priority write allowed while nesting disabled");

endmodule
`default_nettype wire

/* File: cpu_source_model.sv */
// behavioural model of the cpu core and peripheral request sources
`timescale 1ns/100ps
`default_nettype none
module cpu_source_model
(
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  input  wire logic        fire,
  input  wire logic [3:0]  trapSel,
  input  wire logic [15:0] req0In,
  input  wire logic [15:0] req1In,
  input  wire logic        disiIn,
  input  wire logic        iplIn,
  output logic             arithTrap,
  output logic             addressTrap,
  output logic             stackTrap,
  output logic             oscFailTrap,
  output logic             timedDisableActive,
  output logic      [15:0] periphReq0,
  output logic      [15:0] periphReq1,
  output logic             iplWriteReq
);
  // sources only ever pulse a set request; they have no way to clear a flag
  always_ff @(posedge core_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      {arithTrap, addressTrap, stackTrap, oscFailTrap} <= 4'h0;
      periphReq0         <= 16'h0000;
      periphReq1         <= 16'h0000;
      timedDisableActive <= 1'b0;
      iplWriteReq        <= 1'b0;
    end
    else
    begin
      {arithTrap, addressTrap, stackTrap, oscFailTrap} <= fire ? trapSel : 4'h0;
      periphReq0         <= fire ? req0In : 16'h0000;
      periphReq1         <= fire ? req1In : 16'h0000;
      timedDisableActive <= disiIn;
      iplWriteReq        <= iplIn;
    end
  end
endmodule
`default_nettype wire

/* File: tb_interrupt_control_flags.sv */
// self-checking testbench of the interrupt control and flag registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(what, exp, got) begin numChecks++; if ((got) !== (exp)) begin nErrors++; \
  $display("ERROR %s expected %h seen %h", what, exp, got); end end
module tb_interrupt_control_flags
  import intc_pkg::*;
;
  logic        core_clk = 1'b0;
  logic        resetN   = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [3:0]  wbSel = 4'h0;
  logic [31:0] wbDat = 32'h00000000;
  logic [31:0] wbDatO;
  logic        wbAck, fire = 1'b0, disiIn = 1'b0, iplIn = 1'b1;
  logic [3:0]  trapSel = 4'h0;
  logic [15:0] req0In = 16'h0000, req1In = 16'h0000;
  logic [4:0]  extPin = 5'h00;
  logic        aT, adT, sT, oT, tDis, iplReq, iplAllow, nest, altSel;
  logic [15:0] pReq0, pReq1, flags0, flags1;
  logic [4:0]  extEdge;
  int          nErrors = 0;
  int          numChecks = 0;

  always #2 core_clk = ~core_clk;

  cpu_source_model cpu_source_model_inst (.core_clk(core_clk), .reset_n(resetN), .fire(fire),
    .trapSel(trapSel), .req0In(req0In), .req1In(req1In), .disiIn(disiIn), .iplIn(iplIn),
    .arithTrap(aT), .addressTrap(adT), .stackTrap(sT), .oscFailTrap(oT),
    .timedDisableActive(tDis), .periphReq0(pReq0), .periphReq1(pReq1), .iplWriteReq(iplReq));

  interrupt_control_flags interrupt_control_flags_inst (.core_clk(core_clk), .reset_n(resetN),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel),
    .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .arithTrap(aT), .addressTrap(adT),
    .stackTrap(sT), .oscFailTrap(oT), .timedDisableActive(tDis), .extPin(extPin),
    .periphReq0(pReq0), .periphReq1(pReq1), .iplWriteReq(iplReq), .iplWriteAllow(iplAllow),
    .nestDisable(nest), .altVectorSelect(altSel), .extEdge(extEdge),
    .requestFlags0(flags0), .requestFlags1(flags1));

  function automatic logic [15:0] expCtl1(input logic n, input logic [3:0] traps);
    return {n, 10'h000, traps, 1'b0};
  endfunction

  function automatic logic [15:0] expCtl2(input logic alt, input logic dis, input logic [4:0] pol);
    return {alt, dis, 9'h000, pol};
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", numChecks, nErrors);
    if (nErrors == 0 && numChecks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // one classic cycle; the wait is bounded so a dead slave cannot hang the run
  task automatic wb(input logic we, input logic [7:0] adr, input logic [15:0] dat,
                    input logic [3:0] sel, output logic [31:0] rd);
    int n;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe  <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDat <= {16'hA5A5, dat};
    n = 0;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1)
    begin
      nErrors++;
      $display("ERROR wb_ack_o expected 1 seen %b", wbAck);
      results();
    end
    else
    begin
      rd = wbDatO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      wbWe  <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] adr, input logic [15:0] dat, input logic [3:0] sel);
    logic [31:0] rd;
    wb(1'b1, adr, dat, sel, rd);
  endtask

  task automatic rdchk(input string what, input logic [7:0] adr, input logic [15:0] exp);
    logic [31:0] rd;
    wb(1'b0, adr, 16'h0000, 4'h3, rd);
    `CHK(what, {16'h0000, exp}, rd)
  endtask

  task automatic pulse(input logic [3:0] t, input logic [15:0] r0, input logic [15:0] r1);
    @(posedge core_clk);
    fire    <= 1'b1;
    trapSel <= t;
    req0In  <= r0;
    req1In  <= r1;
    @(posedge core_clk);
    fire <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic pin(input int i, input logic v);
    @(posedge core_clk);
    extPin[i] <= v;
  endtask

  // edge pulse lands about three cycles after the pin moves; eight covers it
  task automatic edgeChk(input int i, input logic exp);
    logic seen;
    seen = 1'b0;
    repeat (8)
    begin
      @(negedge core_clk);
      if (extEdge[i] === 1'b1)
        seen = 1'b1;
    end
    `CHK("extEdge", exp, seen)
  endtask

  initial
  begin
    logic [15:0] r0, r1;
    void'($urandom(32'h2320));
    repeat (4) @(posedge core_clk);
    resetN <= 1'b1;
    rdchk("ctl1", CTL1_OFS, 16'h0000);
    rdchk("ctl2", CTL2_OFS, 16'h0000);
    rdchk("flags0", FLAGS0_OFS, 16'h0000);
    rdchk("flags1", FLAGS1_OFS, 16'h0000);
    wr(8'h10, 16'hFFFF, 4'h3);
    rdchk("unmapped", 8'h10, 16'h0000);
    rdchk("ctl1", CTL1_OFS, 16'h0000);
    $display("test reset done");
    wr(CTL1_OFS, 16'hFFFF, 4'h1);
    rdchk("ctl1", CTL1_OFS, expCtl1(1'b0, 4'hF));
    wr(CTL1_OFS, 16'hFFFF, 4'h3);
    rdchk("ctl1", CTL1_OFS, expCtl1(1'b1, 4'hF));
    @(negedge core_clk);
    `CHK("nestDisable", 1'b1, nest)
    `CHK("iplWriteAllow", 1'b0, iplAllow)
    wr(CTL1_OFS, 16'h0000, 4'h3);
    @(negedge core_clk);
    `CHK("nestDisable", 1'b0, nest)
    `CHK("iplWriteAllow", 1'b1, iplAllow)
    for (int t = 0; t < 4; t++)
    begin
      pulse(4'h1 << t, 16'h0000, 16'h0000);
      rdchk("ctl1", CTL1_OFS, expCtl1(1'b0, 4'h1 << t));
      wr(CTL1_OFS, 16'h0000, 4'h3);
    end
    rdchk("ctl1", CTL1_OFS, 16'h0000);
    $display("test control one done");
    wr(CTL2_OFS, 16'hFFFF, 4'h3);
    rdchk("ctl2", CTL2_OFS, expCtl2(1'b1, 1'b0, 5'h1F));
    @(negedge core_clk);
    `CHK("altVectorSelect", 1'b1, altSel)
    @(posedge core_clk);
    disiIn <= 1'b1;
    wr(CTL2_OFS, 16'h0000, 4'h3);
    rdchk("ctl2", CTL2_OFS, expCtl2(1'b0, 1'b1, 5'h00));
    @(negedge core_clk);
    `CHK("altVectorSelect", 1'b0, altSel)
    @(posedge core_clk);
    disiIn <= 1'b0;
    repeat (2) @(posedge core_clk);
    rdchk("ctl2", CTL2_OFS, 16'h0000);
    $display("test control two done");
    for (int b = 0; b < 16; b++)
    begin
      pulse(4'h0, 16'h0001 << b, 16'h0001 << b);
      rdchk("flags0", FLAGS0_OFS, (16'h0001 << b) & FLAGS0_MASK);
      rdchk("flags1", FLAGS1_OFS, (16'h0001 << b) & FLAGS1_MASK);
      wr(FLAGS0_OFS, 16'h0000, 4'h3);
      wr(FLAGS1_OFS, 16'h0000, 4'h3);
    end
    for (int k = 0; k < 6; k++)
    begin
      r0 = 16'($urandom());
      r1 = 16'($urandom());
      pulse(4'h0, r0, r1);
      @(negedge core_clk);
      `CHK("requestFlags0", r0 & FLAGS0_MASK, flags0)
      `CHK("requestFlags1", r1 & FLAGS1_MASK, flags1)
      wr(FLAGS0_OFS, 16'h0000, 4'h1);
      rdchk("flags0", FLAGS0_OFS, r0 & FLAGS0_MASK & 16'hFF00);
      wr(FLAGS0_OFS, 16'h0000, 4'h3);
      wr(FLAGS1_OFS, 16'h0000, 4'h3);
      rdchk("flags1", FLAGS1_OFS, 16'h0000);
    end
    // request and clearing write meet on the ack edge; the request must win
    fork
      wr(FLAGS1_OFS, 16'h0000, 4'h3);
      pulse(4'h0, 16'h0000, 16'h0001);
    join
    rdchk("flags1", FLAGS1_OFS, 16'h0001);
    wr(FLAGS1_OFS, 16'hFFFF, 4'h3);
    rdchk("flags1", FLAGS1_OFS, FLAGS1_MASK);
    wr(FLAGS1_OFS, 16'h0000, 4'h3);
    $display("test flags done");
    for (int i = 0; i < 5; i++)
    begin
      pin(i, 1'b1);
      edgeChk(i, 1'b1);
      wr(CTL2_OFS, {11'h000, 5'h01 << i}, 4'h3);
      pin(i, 1'b0);
      edgeChk(i, 1'b1);
      pin(i, 1'b1);
      edgeChk(i, 1'b0);
      wr(CTL2_OFS, 16'h0000, 4'h3);
      pin(i, 1'b0);
      edgeChk(i, 1'b0);
    end
    rdchk("flags0", FLAGS0_OFS, 16'h0001);
    rdchk("flags1", FLAGS1_OFS, 16'h2010);
    $display("test external pins done");
    wr(CTL1_OFS, 16'hFFFF, 4'h3);
    wr(CTL2_OFS, 16'hFFFF, 4'h3);
    @(posedge core_clk);
    resetN <= 1'b0;
    repeat (4) @(posedge core_clk);
    resetN <= 1'b1;
    @(negedge core_clk);
    `CHK("nestDisable", 1'b0, nest)
    `CHK("altVectorSelect", 1'b0, altSel)
    rdchk("ctl1", CTL1_OFS, 16'h0000);
    rdchk("ctl2", CTL2_OFS, 16'h0000);
    rdchk("flags0", FLAGS0_OFS, 16'h0000);
    rdchk("flags1", FLAGS1_OFS, 16'h0000);
    $display("test second reset done");
    results();
  end
endmodule
`default_nettype wire
